// *** src/accel_ctrl_regs.sv ***
//
// Purpose: control register bank with interrupt pad shaping
// Assumes: byte register port synchronous to clock, one access per cycle
// Notes:   event inputs are one-cycle pulses or levels from the engines
`timescale 1ns/1ps
module accel_ctrl_regs (
	input wire logic clock,
	input wire logic rst,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	input wire logic [1:0] power_profile,
	input wire logic [7:0] tempByte,
	input wire accel_ctrl_pkg::events_t events,
	input wire logic resultStored,
	input wire logic irq_pin_b_in,
	output logic oneshotStart,
	output accel_ctrl_pkg::self_check_t self_check_sel,
	output accel_ctrl_pkg::filter_cfg_t filterCfg,
	output logic irq_pin_a_out,
	output logic irq_pin_a_oe_n,
	output logic irq_pin_b_out,
	output logic irq_pin_b_oe_n
);
	import accel_ctrl_pkg::*;

	// -------------------------------------------------------------
	// register state
	// -------------------------------------------------------------
	logic [7:0] styleReg;
	logic [7:0] pinARoute;
	logic [7:0] pinBRoute;
	logic [7:0] filterReg;
	logic [7:0] tempHold;
	logic pinBPrev;
	logic pinALatched;
	logic pinBLatched;
	logic busy;

	logic pad_drive_type;
	logic latch_irq;
	logic irq_polarity;
	logic oneshot_trigger_src;
	logic oneshot_go;
	assign pad_drive_type = styleReg[PAD_DRIVE_BIT];
	assign latch_irq = styleReg[LATCH_BIT];
	assign irq_polarity = styleReg[POLARITY_BIT];
	assign oneshot_trigger_src = styleReg[TRIG_SRC_BIT];
	assign oneshot_go = styleReg[GO_BIT];

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = regWrite && (a == o);
	endfunction

	// -------------------------------------------------------------
	// control registers
	// -------------------------------------------------------------
	// go bit: hardware clear on result, host set wins in the same cycle
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			styleReg <= CTRL_RESET;
		end else begin
			if (hit(regAddr, IRQ_STYLE_SELFTEST_CTRL)) begin
				styleReg <= regWdata & STYLE_MASK;
			end else if (resultStored && busy) begin
				styleReg[GO_BIT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pinARoute <= CTRL_RESET;
		end else if (hit(regAddr, FIRST_PIN_ROUTING)) begin
			pinARoute <= regWdata & PIN_A_MASK;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pinBRoute <= CTRL_RESET;
		end else if (hit(regAddr, SECOND_PIN_ROUTING)) begin
			pinBRoute <= regWdata & PIN_B_MASK;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			filterReg <= CTRL_RESET;
		end else if (hit(regAddr, FILTER_RANGE_CTRL)) begin
			filterReg <= regWdata & FILTER_MASK;
		end
	end

	// -------------------------------------------------------------
	// one-shot conversion
	// -------------------------------------------------------------
	logic pinBRise;
	logic goWritten;
	logic startNow;
	assign pinBRise = irq_pin_b_in && !pinBPrev;
	// a write that sets source and go together starts at once
	assign goWritten = hit(regAddr, IRQ_STYLE_SELFTEST_CTRL) &&
	    regWdata[GO_BIT] && regWdata[TRIG_SRC_BIT];
	// the pad edge only counts while the source bit selects it
	assign startNow = goWritten || (!oneshot_trigger_src && pinBRise);

	// resets to the pad's idle low level, so no false edge after reset
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pinBPrev <= 1'b0;
		end else begin
			pinBPrev <= irq_pin_b_in;
		end
	end

	// further triggers ignored until the result is stored
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
		end else if (!busy) begin
			busy <= startNow;
		end else if (resultStored) begin
			busy <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			oneshotStart <= 1'b0;
		end else begin
			oneshotStart <= startNow && !busy;
		end
	end

	// -------------------------------------------------------------
	// decoded settings
	// -------------------------------------------------------------
	// high-pass path has no first-stage-only code; 00 acts as 01
	function automatic cutoff_t cutoffCode(input logic hp,
	    input logic [1:0] bw);
		if (hp && bw == 2'h0) begin
			cutoffCode = CUT_DIV4;
		end else begin
			cutoffCode = cutoff_t'(bw);
		end
	endfunction

	function automatic logic [11:0] firstCut(input logic [1:0] prof);
		unique case (prof)
			2'h0: firstCut = FIRST_CUT_P1_HZ;
			2'h1: firstCut = FIRST_CUT_P2_HZ;
			2'h2: firstCut = FIRST_CUT_P3_HZ;
			2'h3: firstCut = FIRST_CUT_P4_HZ;
		endcase
	endfunction

	filter_cfg_t next_filterCfg;
	always_comb begin
		next_filterCfg.highPass = filterReg[FILTER_PATH_BIT];
		next_filterCfg.cutoff = cutoffCode(filterReg[FILTER_PATH_BIT],
		    filterReg[BANDWIDTH_LSB +: 2]);
		next_filterCfg.firstCutHz = firstCut(power_profile);
		next_filterCfg.resolution = (power_profile == 2'h0) ? RES_LOW
		    : RES_HIGH;
		// upper range codes are not defined; treat as widest range
		next_filterCfg.rangeG = (filterReg[RANGE_LSB +: 2] == 2'h0)
		    ? RANGE_2G : RANGE_4G;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			self_check_sel <= CHECK_NORMAL;
		end else begin
			self_check_sel <= self_check_t'(styleReg[SELF_CHECK_LSB +: 2]);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			filterCfg <= '0;
		end else begin
			filterCfg <= next_filterCfg;
		end
	end

	// -------------------------------------------------------------
	// interrupt pads
	// -------------------------------------------------------------
	logic pinASrc;
	logic pinBSrc;
	assign pinASrc = |({events.orient, events.wakeup, events.freefall,
	    events.bufFull, events.bufLevel, events.sampleReady}
	    & {pinARoute[7], pinARoute[5:4], pinARoute[2:0]});
	assign pinBSrc = |({events.sleepLevel, events.sleepChange,
	    events.trimLoad, events.tempReady, events.bufOverrun,
	    events.bufFull, events.bufLevel, events.sampleReady}
	    & pinBRoute);

	logic readTemp;
	assign readTemp = regRead && regAddr == TEMPERATURE_BYTE;

	// latched request clears when the host reads the temperature-free
	// style register; a new event in the same cycle keeps it set
	logic latchClear;
	assign latchClear = regRead && regAddr == IRQ_STYLE_SELFTEST_CTRL;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pinALatched <= 1'b0;
		end else begin
			pinALatched <= latch_irq && (pinASrc ||
			    (pinALatched && !latchClear));
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pinBLatched <= 1'b0;
		end else begin
			pinBLatched <= latch_irq && (pinBSrc ||
			    (pinBLatched && !latchClear));
		end
	end

	logic pinAActive;
	logic pinBActive;
	assign pinAActive = latch_irq ? (pinASrc || pinALatched) : pinASrc;
	assign pinBActive = latch_irq ? (pinBSrc || pinBLatched) : pinBSrc;

	// pad level after polarity, shared by both pads
	function automatic logic padLevel(input logic active, input logic pol);
		padLevel = active ^ pol;
	endfunction

	// open drain only pulls the wire low, so it releases whenever the pad level is high
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_pin_a_out <= 1'b0;
			irq_pin_a_oe_n <= 1'b0;
		end else begin
			irq_pin_a_out <= padLevel(pinAActive, irq_polarity);
			irq_pin_a_oe_n <= pad_drive_type &&
			    padLevel(pinAActive, irq_polarity);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_pin_b_out <= 1'b0;
			irq_pin_b_oe_n <= 1'b0;
		end else begin
			irq_pin_b_out <= padLevel(pinBActive, irq_polarity);
			irq_pin_b_oe_n <= pad_drive_type &&
			    padLevel(pinBActive, irq_polarity);
		end
	end

	// -------------------------------------------------------------
	// readback
	// -------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tempHold <= CTRL_RESET;
		end else if (!readTemp) begin
			tempHold <= tempByte;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			regRdata <= CTRL_RESET;
		end else if (regRead) begin
			unique case (regAddr)
				IRQ_STYLE_SELFTEST_CTRL: regRdata <= styleReg;
				FIRST_PIN_ROUTING: regRdata <= pinARoute;
				SECOND_PIN_ROUTING: regRdata <= pinBRoute;
				FILTER_RANGE_CTRL: regRdata <= filterReg;
				TEMPERATURE_BYTE: regRdata <= tempHold;
				default: regRdata <= CTRL_RESET;
			endcase
		end
	end

endmodule

// *** src/accel_ctrl_pkg.sv ***
//
// Purpose: constants and types for the motion sensor control register bank
// Assumes: 8-bit register port with byte addresses as printed
// Notes:   field positions and reset values live here only
//
package accel_ctrl_pkg;

	// -------------------------------------------------------------
	// register offsets
	// -------------------------------------------------------------
	localparam logic [7:0] IRQ_STYLE_SELFTEST_CTRL = 8'h22;
	localparam logic [7:0] FIRST_PIN_ROUTING = 8'h23;
	localparam logic [7:0] SECOND_PIN_ROUTING = 8'h24;
	localparam logic [7:0] FILTER_RANGE_CTRL = 8'h25;
	localparam logic [7:0] TEMPERATURE_BYTE = 8'h26;

	// -------------------------------------------------------------
	// reset values and writable masks
	// -------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] STYLE_MASK = 8'hFB;
	localparam logic [7:0] PIN_A_MASK = 8'hB7;
	localparam logic [7:0] PIN_B_MASK = 8'hFF;
	localparam logic [7:0] FILTER_MASK = 8'hF8;

	// -------------------------------------------------------------
	// field positions
	// -------------------------------------------------------------
	localparam int SELF_CHECK_LSB = 6;
	localparam int PAD_DRIVE_BIT = 5;
	localparam int LATCH_BIT = 4;
	localparam int POLARITY_BIT = 3;
	localparam int TRIG_SRC_BIT = 1;
	localparam int GO_BIT = 0;
	localparam int BANDWIDTH_LSB = 6;
	localparam int RANGE_LSB = 4;
	localparam int FILTER_PATH_BIT = 3;

	// -------------------------------------------------------------
	// decoded settings
	// -------------------------------------------------------------
	typedef enum logic [1:0] {
		CHECK_NORMAL = 2'h0,
		CHECK_POSITIVE = 2'h1,
		CHECK_NEGATIVE = 2'h2,
		CHECK_UNDEFINED = 2'h3
	} self_check_t;

	// cutoff codes: 0 first stage only, 1 rate/4, 2 rate/10, 3 rate/20
	typedef enum logic [1:0] {
		CUT_FIRST_ONLY = 2'h0,
		CUT_DIV4 = 2'h1,
		CUT_DIV10 = 2'h2,
		CUT_DIV20 = 2'h3
	} cutoff_t;

	localparam logic [11:0] FIRST_CUT_P1_HZ = 12'hC80;
	localparam logic [11:0] FIRST_CUT_P2_HZ = 12'h2D0;
	localparam logic [11:0] FIRST_CUT_P3_HZ = 12'h168;
	localparam logic [11:0] FIRST_CUT_P4_HZ = 12'h0B4;
	localparam logic [4:0] RANGE_2G = 5'h02;
	localparam logic [4:0] RANGE_4G = 5'h04;
	localparam logic [4:0] RES_LOW = 5'h0C;
	localparam logic [4:0] RES_HIGH = 5'h0E;

	// routed event sources
	typedef struct packed {
		logic orient;
		logic wakeup;
		logic freefall;
		logic bufFull;
		logic bufLevel;
		logic sampleReady;
		logic sleepLevel;
		logic sleepChange;
		logic trimLoad;
		logic tempReady;
		logic bufOverrun;
	} events_t;

	// filter and range settings handed to the datapath
	typedef struct packed {
		logic highPass;
		cutoff_t cutoff;
		logic [11:0] firstCutHz;
		logic [4:0] rangeG;
		logic [4:0] resolution;
	} filter_cfg_t;

endpackage

// *** dv/accel_ctrl_regs_sva.sv ***
// Purpose: port checks for the control register bank
// Assumes: one clock, async active-high reset
// Notes:   bound to every accel_ctrl_regs instance
`timescale 1ns/1ps
module accel_ctrl_regs_sva (
	input wire logic clock,
	input wire logic rst,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic [7:0] regRdata,
	input wire logic [7:0] tempByte,
	input wire logic resultStored,
	input wire logic irq_pin_b_in,
	input wire logic oneshotStart,
	input wire logic irq_pin_a_out,
	input wire logic irq_pin_a_oe_n,
	input wire logic irq_pin_b_out,
	input wire logic irq_pin_b_oe_n
);
	import accel_ctrl_pkg::*;
	logic busy;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// -------------------------------------------------------------
	// conversion tracker: a start while busy is ignored by design
	// -------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			busy <= 1'b0;
		else if (oneshotStart)
			busy <= 1'b1;
		else if (resultStored)
			busy <= 1'b0;
	end
	sequence s_go_write;
		regWrite && regAddr == IRQ_STYLE_SELFTEST_CTRL &&
			regWdata[1:0] == 2'b11 && !busy && !oneshotStart;
	endsequence
	chk_go_starts: assert property (s_go_write |=> oneshotStart)
		else $error("go write gave no start");
	chk_start_single: assert property (oneshotStart |=> !oneshotStart)
		else $error("start pulse too long");
	chk_start_cause: assert property (oneshotStart |->
		$past(regWrite && regAddr == IRQ_STYLE_SELFTEST_CTRL && regWdata[0])
		|| $past(irq_pin_b_in) || $past(irq_pin_b_in, 2))
		else $error("start without trigger");
	// the held byte lags the live one by a cycle
	chk_temp_read: assert property (regRead && regAddr == TEMPERATURE_BYTE
		&& !$past(regRead && regAddr == TEMPERATURE_BYTE)
		|=> regRdata == $past(tempByte, 2)) else $error("temperature misread");
	chk_unmapped_read: assert property (regRead &&
		(regAddr < 8'h22 || regAddr > 8'h26) |=> regRdata == 8'h00)
		else $error("unmapped read not zero");
	chk_rdata_holds: assert property (!$past(regRead) |-> $stable(regRdata))
		else $error("read data moved");
	chk_pad_a_release: assert property (irq_pin_a_oe_n |-> irq_pin_a_out)
		else $error("pad a released low");
	chk_pad_b_release: assert property (irq_pin_b_oe_n |-> irq_pin_b_out)
		else $error("pad b released low");
endmodule
bind accel_ctrl_regs accel_ctrl_regs_sva chk_u (.clock, .rst, .regWrite,
	.regRead, .regAddr, .regWdata, .regRdata, .tempByte, .resultStored,
	.irq_pin_b_in, .oneshotStart, .irq_pin_a_out, .irq_pin_a_oe_n,
	.irq_pin_b_out, .irq_pin_b_oe_n);

// *** dv/host_model.sv ***
// Purpose: host side of the byte register port
// Assumes: strobes launched and dropped at falling edges
// Notes:   released address lines show inverted data; rd leaves regWdata at its last value
`timescale 1ns/1ps
module host_model (
	input wire logic clock,
	output logic regWrite,
	output logic regRead,
	output logic [7:0] regAddr,
	output logic [7:0] regWdata,
	input wire logic [7:0] regRdata
);
	initial begin
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 8'h00;
		regWdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		regWrite = 1'b1;
		regAddr = a;
		regWdata = d;
		@(negedge clock);
		regWrite = 1'b0;
		regAddr = ~a;
		regWdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		regRead = 1'b1;
		regAddr = a;
		@(negedge clock);
		regRead = 1'b0;
		regAddr = ~a;
		d = regRdata;
	endtask
endmodule

// *** dv/accel_irq_filter_control_regs_bench.sv ***
// Purpose: self-checking bench for the control register bank
// Assumes: all inputs change at falling edges
// Notes:   pads checked in pulsed, latched and open-drain styles
`timescale 1ns/1ps
module accel_irq_filter_control_regs_bench;
	import accel_ctrl_pkg::*;
	logic clock = 1'b0, rst = 1'b1, resultStored = 1'b0, irq_pin_b_in = 1'b0;
	logic regWrite, regRead, oneshotStart, s;
	logic irq_pin_a_out, irq_pin_a_oe_n, irq_pin_b_out, irq_pin_b_oe_n;
	logic [7:0] regAddr, regWdata, regRdata, v, tempByte = 8'h5A;
	logic [1:0] power_profile = 2'h0;
	events_t events = '0;
	self_check_t self_check_sel;
	filter_cfg_t filterCfg;
	int mismatches = 0, check_count = 0, cycles = 0;
	// pin b flag, routing bit, event bit
	logic [8:0] pads[14] = '{9'h07A, 9'h059, 9'h048, 9'h027, 9'h016, 9'h005,
		9'h174, 9'h163, 9'h152, 9'h141, 9'h130, 9'h127, 9'h116, 9'h105};
	logic [7:0] masks[5] = '{STYLE_MASK, PIN_A_MASK, PIN_B_MASK, FILTER_MASK,
		8'h5A};
	logic [15:0] cuts[4] = '{16'h0C80, 16'h02D0, 16'h0168, 16'h00B4};
	always #5 clock = ~clock;
	host_model host_u (.clock, .regWrite, .regRead, .regAddr, .regWdata,
		.regRdata);
	accel_ctrl_regs dut_u (.clock, .rst, .regWrite, .regRead, .regAddr,
		.regWdata, .regRdata, .power_profile, .tempByte, .events,
		.resultStored, .irq_pin_b_in, .oneshotStart, .self_check_sel,
		.filterCfg, .irq_pin_a_out, .irq_pin_a_oe_n, .irq_pin_b_out,
		.irq_pin_b_oe_n);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic pulse(input events_t e, input logic pb, output logic seen);
		@(negedge clock);
		events = e;
		seen = 1'b0;
		repeat (3) begin
			@(negedge clock);
			events = '0;
			seen |= pb ? irq_pin_b_out : irq_pin_a_out;
		end
	endtask
	task automatic stop_test();
		if (mismatches == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			stop_test();
		end
	end
	initial begin
		repeat (12) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		for (int i = 0; i < 4; i++) begin
			host_u.rd(8'h22 + 8'(i), v);
			chk(16'(v), 16'(CTRL_RESET));
		end
		for (int i = 0; i < 5; i++) begin
			host_u.wr(8'h22 + 8'(i), 8'hFF);
			host_u.rd(8'h22 + 8'(i), v);
			chk(16'(v), 16'(masks[i]));
		end
		host_u.rd(8'h27, v);
		chk(16'(v), 16'h0000);
		tempByte = 8'hC3;
		host_u.rd(TEMPERATURE_BYTE, v);
		chk(16'(v), 16'h00C3);
		resultStored = 1'b1;
		idle(1);
		resultStored = 1'b0;
		host_u.rd(IRQ_STYLE_SELFTEST_CTRL, v);
		chk(16'(v), 16'h00FA);
		for (int c = 0; c < 4; c++) begin
			host_u.wr(IRQ_STYLE_SELFTEST_CTRL, 8'(c << 6));
			idle(2);
			chk(16'(self_check_sel), 16'(c));
		end
		for (int m = 0; m < 2; m++) begin
			host_u.wr(IRQ_STYLE_SELFTEST_CTRL, 8'(m << 1));
			irq_pin_b_in = 1'b1;
			s = 1'b0;
			repeat (4) begin
				idle(1);
				s |= oneshotStart;
			end
			irq_pin_b_in = 1'b0;
			chk(16'(s), 16'(m == 0));
			resultStored = 1'b1;
			idle(1);
			resultStored = 1'b0;
		end
		host_u.wr(IRQ_STYLE_SELFTEST_CTRL, 8'h03);
		chk(16'(oneshotStart), 16'h0001);
		host_u.wr(IRQ_STYLE_SELFTEST_CTRL, 8'h03);
		chk(16'(oneshotStart), 16'h0000);
		resultStored = 1'b1;
		idle(1);
		resultStored = 1'b0;
		host_u.rd(IRQ_STYLE_SELFTEST_CTRL, v);
		chk(16'(v), 16'h0002);
		for (int k = 0; k < 8; k++) begin
			host_u.wr(FILTER_RANGE_CTRL, {k[2:1], k[2:1], k[0], 3'b000});
			power_profile = k[1:0];
			idle(2);
			v = (k[0] && k[2:1] == 2'b00) ? 8'h01 : 8'(k[2:1]);
			chk(16'(filterCfg.highPass), 16'(k[0]));
			chk(16'(filterCfg.cutoff), 16'(v));
			chk(16'(filterCfg.rangeG), k[2:1] == 0 ? 16'h0002 : 16'h0004);
			chk(16'(filterCfg.firstCutHz), cuts[k[1:0]]);
			chk(16'(filterCfg.resolution), k[1:0] == 0 ? 16'h000C : 16'h000E);
		end
		host_u.wr(IRQ_STYLE_SELFTEST_CTRL, 8'h00);
		foreach (pads[i]) begin
			v = 8'(1 << pads[i][7:4]);
			host_u.wr(FIRST_PIN_ROUTING, pads[i][8] ? 8'h00 : v);
			host_u.wr(SECOND_PIN_ROUTING, pads[i][8] ? v : 8'h00);
			pulse(events_t'(~(11'h001 << pads[i][3:0])), pads[i][8], s);
			chk(16'(s), 16'h0000);
			pulse(events_t'(11'h001 << pads[i][3:0]), pads[i][8], s);
			chk(16'(s), 16'h0001);
		end
		host_u.wr(FIRST_PIN_ROUTING, 8'h20);
		host_u.wr(SECOND_PIN_ROUTING, 8'h00);
		host_u.wr(IRQ_STYLE_SELFTEST_CTRL, 8'h18);
		idle(2);
		chk(16'({irq_pin_a_out, irq_pin_a_oe_n, irq_pin_b_out,
			irq_pin_b_oe_n}), 16'h000A);
		pulse(events_t'(11'h200), 1'b0, s);
		idle(3);
		chk(16'(irq_pin_a_out), 16'h0000);
		host_u.rd(IRQ_STYLE_SELFTEST_CTRL, v);
		chk(16'(v), 16'h0018);
		idle(2);
		chk(16'(irq_pin_a_out), 16'h0001);
		host_u.wr(IRQ_STYLE_SELFTEST_CTRL, 8'h38);
		idle(2);
		chk(16'({irq_pin_a_out, irq_pin_a_oe_n, irq_pin_b_out,
			irq_pin_b_oe_n}), 16'h000F);
		pulse(events_t'(11'h200), 1'b0, s);
		chk(16'({irq_pin_a_out, irq_pin_a_oe_n, irq_pin_b_out,
			irq_pin_b_oe_n}), 16'h0003);
		stop_test();
	end
endmodule
